/* File: logic/xload_pkg.sv */
// Constants, types and helpers for the binary load and unload engine
package xload_pkg;

  // Clock and receive deadline
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYC_DEF  = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TMO_SEC       = 60;
  localparam int unsigned TMO_TICKS_DEF = TMO_SEC * 1000 / TICK_MS;

  // Character codes
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_RUB   = 8'h7F;
  localparam logic [7:0] CH_CMT   = 8'h21;
  localparam logic [7:0] CH_XU    = 8'h58;
  localparam logic [7:0] CH_XL    = 8'h78;
  localparam logic [7:0] CH_CTL_C = 8'h03;
  localparam logic [7:0] CH_CTL_O = 8'h0F;
  localparam logic [7:0] CH_CTL_Q = 8'h11;
  localparam logic [7:0] CH_CTL_S = 8'h13;

  // Count field layout
  localparam int unsigned DIR_BIT = 31;

  // Line buffer
  localparam int unsigned LBUF_DEPTH = 32;
  localparam int unsigned LBUF_AW    = 5;
  localparam int unsigned LBUF_LW    = LBUF_AW + 1;

  // Message text: error line then prompt
  localparam logic [71:0] MSG_TEXT =
    {8'h3F, 8'h45, 8'h52, 8'h52, CH_CR, CH_LF, 8'h3E, 8'h3E, 8'h3E};
  localparam logic [3:0] MSG_ERR_IDX = 4'h0;
  localparam logic [3:0] MSG_PRM_IDX = 4'h6;
  localparam logic [3:0] MSG_LAST    = 4'h8;

  // Engine states, Gray coded along the load path
  typedef enum logic [3:0] {
    ST_LINE   = 4'h0,
    ST_PARSE  = 4'h1,
    ST_WCHK   = 4'h3,
    ST_MSG    = 4'h2,
    ST_LD_RX  = 4'h6,
    ST_LD_WR  = 4'h7,
    ST_UL_RD  = 4'h5,
    ST_UL_TX  = 4'h4,
    ST_UL_SUM = 4'hC
  } st_t;

  // Command line field being parsed
  typedef enum logic [1:0] {
    FLD_CMD  = 2'h0,
    FLD_ADDR = 2'h1,
    FLD_CNT  = 2'h3,
    FLD_END  = 2'h2
  } fld_t;

  // Hex digit decode: {valid, value}
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 8'h30 && c <= 8'h39) begin
      r = {1'b1, 4'(c - 8'h30)};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      r = {1'b1, 4'(c - 8'h37)};
    end else if (c >= 8'h61 && c <= 8'h66) begin
      r = {1'b1, 4'(c - 8'h57)};
    end
    return r;
  endfunction : hex_val

endpackage : xload_pkg

/* File: logic/xload_timer.sv */
// Receive deadline timer with a millisecond tick divider
`timescale 1ns/1ps
module xload_timer
  import xload_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC_DEF,
  parameter int unsigned TMO_TICKS   = TMO_TICKS_DEF
) (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  input  wire logic clr_in,
  output logic      expired_out
);
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
  localparam int unsigned MW = $clog2(TMO_TICKS + 1);

  logic [TW-1:0] tick_ff;
  logic [MW-1:0] ms_ff;
  logic          exp_ff;
  wire           tick_en = run_in && (tick_ff == TW'(TICK_CYCLES - 1));
  wire           at_end  = (ms_ff == MW'(TMO_TICKS - 1));

  // Divider makes a one-cycle tick, tick counter flags the deadline
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_ff <= '0;
      ms_ff   <= '0;
      exp_ff  <= 1'b0;
    end else if (clr_in) begin
      tick_ff <= '0;
      ms_ff   <= '0;
      exp_ff  <= 1'b0;
    end else if (run_in) begin
      tick_ff <= tick_en ? '0 : TW'(tick_ff + 1'b1);
      ms_ff   <= (tick_en && !at_end) ? MW'(ms_ff + 1'b1) : ms_ff;
      exp_ff  <= tick_en && at_end;
    end else begin
      exp_ff  <= 1'b0;
    end
  end

  assign expired_out = exp_ff;
endmodule : xload_timer

/* File: logic/xload_engine.sv */
// Console engine for binary load and unload over the serial line
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - Count top bit selects load or unload
// RULE_02 - Other count bits give the byte count
// RULE_03 - Transfer starts at the command address
// RULE_04 - CR accepts line; next byte is checksum
// RULE_05 - Line bytes plus checksum sum to zero
// RULE_06 - Good checksum prompts, bad one reports error
// RULE_07 - Load stores counted bytes, then data checksum
// RULE_08 - Load checksum nonzero gives error message
// RULE_09 - Unload sends bytes, then negated sum
// RULE_10 - Errors reported only after whole transfer
// RULE_11 - Failed load leaves memory undefined
// RULE_12 - No echo of data or checksums
// RULE_13 - Flow control stops after command CR
// RULE_14 - Unload obeys control chars, load does not
// RULE_15 - Host sends data bytes within 60 s
// RULE_16 - Host sends command checksum within 60 s
// RULE_17 - Host sends data checksum within 60 s
// RULE_18 - Missed deadline aborts with error message
// RULE_19 - Full rate command burst loses nothing
// RULE_20 - At least 4 Kbytes per command
// RULE_21 - Text after comment character is dropped
// RULE_22 - Address rises by one per byte
module xload_engine
  import xload_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC_DEF,
  parameter int unsigned TMO_TICKS   = TMO_TICKS_DEF
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_err_in,
  input  wire logic        tx_ready_in,
  output logic             tx_valid_out,
  output logic [7:0]       tx_data_out,
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic [31:0]      mem_addr_out,
  output logic [7:0]       mem_wdata_out,
  input  wire logic        mem_ack_in,
  input  wire logic [7:0]  mem_rdata_in,
  input  wire logic        mem_err_in,
  output logic             flow_ctl_en_out
);
  st_t          st_ff, nxt_st, after_ff, nxt_after;
  fld_t         fld_ff, nxt_fld;
  logic [7:0]   buf_ff [LBUF_DEPTH];
  logic [LBUF_AW:0] len_ff, nxt_len, pidx_ff, nxt_pidx;
  logic         cmt_ff, nxt_cmt, dig_ff, nxt_dig, bad_ff, nxt_bad;
  logic [31:0]  addr_ff, nxt_addr, cnt_ff, nxt_cnt;
  logic         dir_ff, nxt_dir, err_ff, nxt_err;
  logic [7:0]   sum_ff, nxt_sum;
  logic [3:0]   mptr_ff, nxt_mptr;
  logic         pause_ff, nxt_pause, supp_ff, nxt_supp, cc_ff, nxt_cc;
  logic         txv_ff, nxt_txv, req_ff, nxt_req, we_ff, nxt_we, flow_ff;
  logic [7:0]   txd_ff, nxt_txd, wd_ff, nxt_wd;
  logic         pend_ff;
  logic [7:0]   hold_ff;
  logic         tmo_exp;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // Character decode of the held receive byte
  wire       tx_free  = !txv_ff;
  wire       is_cr    = (hold_ff == CH_CR);
  wire       is_cmt   = (hold_ff == CH_CMT);
  wire       is_rub   = (hold_ff == CH_RUB);
  wire       buf_full = (len_ff == LBUF_LW'(LBUF_DEPTH));
  wire [7:0] pc       = buf_ff[pidx_ff[LBUF_AW-1:0]];
  wire [4:0] pc_hex   = hex_val(pc);
  wire       pc_x     = (pc == CH_XU) || (pc == CH_XL);
  wire [7:0] sum_in   = 8'(sum_ff + hold_ff);
  wire [7:0] msg_ch   = MSG_TEXT[(MSG_LAST - mptr_ff) * 8 +: 8];
  wire       ld_st    = (st_ff == ST_LD_RX) || (st_ff == ST_LD_WR);
  wire       ul_st    = (st_ff == ST_UL_RD) || (st_ff == ST_UL_TX) ||
                        (st_ff == ST_UL_SUM);
  wire       line_tk  = pend_ff && tx_free && (st_ff == ST_LINE);  // [RULE_12]
  wire       rx_take  = line_tk || (pend_ff && (st_ff == ST_WCHK ||
                        st_ff == ST_LD_RX || ul_st));
  wire       buf_wr   = line_tk && !is_cr && !cmt_ff && !is_cmt &&
                        !is_rub && !buf_full;
  wire       tmr_run  = (st_ff == ST_WCHK) || ld_st;
  wire       tmr_clr  = rx_take || (st_ff == ST_PARSE);

  // Deadline between command end, data bytes and data checksum
  xload_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .TMO_TICKS   (TMO_TICKS)
  ) u_timer (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .run_in      (tmr_run),  // [RULE_15] [RULE_16] [RULE_17]
    .clr_in      (tmr_clr),
    .expired_out (tmo_exp)
  );

  // One byte hold register keeps a burst from being dropped
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_ff <= 1'b0;
      hold_ff <= 8'h00;
    end else if (rx_valid_in) begin
      pend_ff <= 1'b1;  // [RULE_19]
      hold_ff <= rx_data_in;
    end else if (rx_take) begin
      pend_ff <= 1'b0;
    end
  end

  // Line buffer entries, written at the current length
  genvar gi;
  generate
    for (gi = 0; gi < LBUF_DEPTH; gi++) begin : g_lbuf
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          buf_ff[gi] <= 8'h00;
        end else if (buf_wr && len_ff[LBUF_AW-1:0] == LBUF_AW'(gi)) begin
          buf_ff[gi] <= hold_ff;
        end
      end
    end
  endgenerate

  // Main sequence: line entry, parse, checksum, message, transfer
  always_comb begin
    nxt_st = st_ff;
    nxt_after = after_ff;
    nxt_fld = fld_ff;
    nxt_len = len_ff;
    nxt_pidx = pidx_ff;
    nxt_cmt = cmt_ff;
    nxt_dig = dig_ff;
    nxt_bad = bad_ff;
    nxt_addr = addr_ff;
    nxt_cnt = cnt_ff;
    nxt_dir = dir_ff;
    nxt_err = err_ff;
    nxt_sum = sum_ff;
    nxt_mptr = mptr_ff;
    nxt_pause = pause_ff;
    nxt_supp = supp_ff;
    nxt_cc = cc_ff;
    nxt_txv = txv_ff && !tx_ready_in;
    nxt_txd = txd_ff;
    nxt_req = req_ff && !mem_ack_in;
    nxt_we = we_ff;
    nxt_wd = wd_ff;
    unique case (st_ff)
      ST_LINE: begin
        if (line_tk) begin
          if (is_cr) begin
            nxt_st = ST_PARSE;  // [RULE_04]
            nxt_pidx = '0;
            nxt_sum = 8'h00;
            nxt_fld = FLD_CMD;
            nxt_dig = 1'b0;
            nxt_bad = 1'b0;
            nxt_addr = 32'h0;
            nxt_cnt = 32'h0;
            nxt_cmt = 1'b0;
          end else if (cmt_ff || is_cmt) begin
            nxt_cmt = 1'b1;  // [RULE_21]
          end else if (is_rub) begin
            if (len_ff != '0) begin
              nxt_len = LBUF_LW'(len_ff - 1'b1);  // [RULE_05]
            end
          end else if (!buf_full) begin
            nxt_len = LBUF_LW'(len_ff + 1'b1);
            nxt_txv = 1'b1;
            nxt_txd = hold_ff;
          end
        end
      end
      ST_PARSE: begin
        if (pidx_ff == len_ff) begin
          nxt_len = '0;
          if (fld_ff == FLD_CMD) begin
            nxt_st = ST_LINE;
          end else begin
            nxt_st = ST_WCHK;
            nxt_bad = bad_ff || !(fld_ff == FLD_END ||
                      (fld_ff == FLD_CNT && dig_ff));
          end
        end else begin
          nxt_pidx = LBUF_LW'(pidx_ff + 1'b1);
          nxt_sum = 8'(sum_ff + pc);  // [RULE_05]
          if (pc == CH_SP) begin
            if (dig_ff && fld_ff == FLD_ADDR) begin
              nxt_fld = FLD_CNT;
              nxt_dig = 1'b0;
            end else if (dig_ff && fld_ff == FLD_CNT) begin
              nxt_fld = FLD_END;
            end
          end else if (fld_ff == FLD_CMD) begin
            if (pc_x) begin
              nxt_fld = FLD_ADDR;
            end else begin
              nxt_pidx = len_ff;
            end
          end else if (pc_hex[4] && fld_ff == FLD_ADDR) begin
            nxt_addr = {addr_ff[27:0], pc_hex[3:0]};  // [RULE_03]
            nxt_dig = 1'b1;
          end else if (pc_hex[4] && fld_ff == FLD_CNT) begin
            nxt_cnt = {cnt_ff[27:0], pc_hex[3:0]};
            nxt_dig = 1'b1;
          end else begin
            nxt_bad = 1'b1;
          end
        end
      end
      ST_WCHK: begin
        nxt_st = ST_MSG;
        nxt_after = ST_LINE;
        nxt_mptr = MSG_ERR_IDX;
        if (tmo_exp) begin
          nxt_st = ST_MSG;  // [RULE_18]
        end else if (pend_ff) begin
          if (sum_in == 8'h00 && !bad_ff) begin
            nxt_mptr = MSG_PRM_IDX;  // [RULE_06]
            nxt_dir = cnt_ff[DIR_BIT];  // [RULE_01]
            nxt_cnt = {1'b0, cnt_ff[DIR_BIT-1:0]};  // [RULE_02] [RULE_20]
            nxt_after = cnt_ff[DIR_BIT] ? ST_UL_RD : ST_LD_RX;
            nxt_sum = 8'h00;
            nxt_err = 1'b0;
            nxt_pause = 1'b0;
            nxt_supp = 1'b0;
            nxt_cc = 1'b0;
          end
        end else begin
          nxt_st = ST_WCHK;
        end
      end
      ST_MSG: begin
        if (tx_free) begin
          nxt_txv = 1'b1;
          nxt_txd = msg_ch;
          nxt_mptr = 4'(mptr_ff + 1'b1);
          if (mptr_ff == MSG_LAST) begin
            nxt_st = after_ff;
            if (after_ff == ST_UL_RD && cnt_ff == 32'h0) begin
              nxt_st = ST_UL_SUM;
            end
          end
        end
      end
      ST_LD_RX: begin
        if (tmo_exp) begin
          nxt_st = ST_MSG;  // [RULE_18]
          nxt_after = ST_LINE;
          nxt_mptr = MSG_ERR_IDX;
        end else if (pend_ff && cnt_ff != 32'h0) begin
          nxt_st = ST_LD_WR;  // [RULE_07] [RULE_14]
          nxt_req = 1'b1;
          nxt_we = 1'b1;
          nxt_wd = hold_ff;
          nxt_sum = sum_in;
        end else if (pend_ff) begin
          // Written bytes stay as they are after a failed load [RULE_11]
          nxt_st = ST_MSG;  // [RULE_08] [RULE_10]
          nxt_after = ST_LINE;
          nxt_mptr = (sum_in != 8'h00 || err_ff) ? MSG_ERR_IDX
                                                 : MSG_PRM_IDX;
        end
      end
      ST_LD_WR: begin
        if (mem_ack_in) begin
          nxt_st = ST_LD_RX;
          nxt_err = err_ff || mem_err_in;  // [RULE_10]
          nxt_addr = 32'(addr_ff + 32'h1);  // [RULE_22]
          nxt_cnt = 32'(cnt_ff - 32'h1);
          nxt_we = 1'b0;
        end
      end
      ST_UL_RD: begin
        if (!req_ff) begin
          nxt_req = 1'b1;
          nxt_we = 1'b0;
        end else if (mem_ack_in) begin
          nxt_st = ST_UL_TX;
          nxt_wd = mem_rdata_in;
          nxt_err = err_ff || mem_err_in;  // [RULE_10]
          nxt_addr = 32'(addr_ff + 32'h1);  // [RULE_22]
        end
      end
      ST_UL_TX: begin
        if (cc_ff) begin
          nxt_st = ST_MSG;  // [RULE_14]
          nxt_after = ST_LINE;
          nxt_mptr = MSG_PRM_IDX;
        end else if (!pause_ff && tx_free) begin
          nxt_txv = !supp_ff;
          nxt_txd = wd_ff;
          nxt_sum = 8'(sum_ff + wd_ff);  // [RULE_09]
          nxt_cnt = 32'(cnt_ff - 32'h1);
          nxt_st = (cnt_ff == 32'h1) ? ST_UL_SUM : ST_UL_RD;
        end
      end
      ST_UL_SUM: begin
        if (!pause_ff && tx_free) begin
          nxt_txv = 1'b1;
          nxt_txd = 8'(8'h00 - sum_ff);  // [RULE_09]
          nxt_st = ST_MSG;
          nxt_after = ST_LINE;
          nxt_mptr = err_ff ? MSG_ERR_IDX : MSG_PRM_IDX;  // [RULE_10]
        end
      end
      default: begin
        nxt_st = ST_LINE;
      end
    endcase
    // Operator control characters act only while unloading
    if (ul_st && pend_ff) begin
      if (hold_ff == CH_CTL_S) nxt_pause = 1'b1;  // [RULE_14]
      if (hold_ff == CH_CTL_Q) nxt_pause = 1'b0;
      if (hold_ff == CH_CTL_O) nxt_supp = !supp_ff;
      if (hold_ff == CH_CTL_C) nxt_cc = 1'b1;
    end
    // Line errors during a load are remembered for the end
    if (ld_st && rx_err_in) begin
      nxt_err = 1'b1;  // [RULE_10]
    end
  end

  // State and datapath registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= ST_LINE;
      after_ff <= ST_LINE;
      fld_ff <= FLD_CMD;
      len_ff <= '0;
      pidx_ff <= '0;
      {cmt_ff, dig_ff, bad_ff, dir_ff, err_ff} <= 5'h00;
      {pause_ff, supp_ff, cc_ff} <= 3'h0;
      addr_ff <= 32'h0;
      cnt_ff <= 32'h0;
      sum_ff <= 8'h00;
      mptr_ff <= 4'h0;
    end else begin
      st_ff <= nxt_st;
      after_ff <= nxt_after;
      fld_ff <= nxt_fld;
      len_ff <= nxt_len;
      pidx_ff <= nxt_pidx;
      {cmt_ff, dig_ff, bad_ff, dir_ff, err_ff} <=
        {nxt_cmt, nxt_dig, nxt_bad, nxt_dir, nxt_err};
      {pause_ff, supp_ff, cc_ff} <= {nxt_pause, nxt_supp, nxt_cc};
      addr_ff <= nxt_addr;
      cnt_ff <= nxt_cnt;
      sum_ff <= nxt_sum;
      mptr_ff <= nxt_mptr;
    end
  end

  // Output registers; flow control only while a line is being typed
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      {txv_ff, req_ff, we_ff} <= 3'h0;
      txd_ff <= 8'h00;
      wd_ff <= 8'h00;
      flow_ff <= 1'b1;
    end else begin
      {txv_ff, req_ff, we_ff} <= {nxt_txv, nxt_req, nxt_we};
      txd_ff <= nxt_txd;
      wd_ff <= nxt_wd;
      flow_ff <= (nxt_st == ST_LINE);  // [RULE_13]
    end
  end

  assign tx_valid_out    = txv_ff;
  assign tx_data_out     = txd_ff;
  assign mem_req_out     = req_ff;
  assign mem_we_out      = we_ff;
  assign mem_addr_out    = addr_ff;
  assign mem_wdata_out   = wd_ff;
  assign flow_ctl_en_out = flow_ff;

  // Checks on the engine's own behaviour
  sequence s_err_msg;
    st_ff == ST_MSG && mptr_ff == MSG_ERR_IDX;
  endsequence

  sequence s_prompt;
    st_ff == ST_MSG && mptr_ff == MSG_PRM_IDX;
  endsequence

  AST_FLOW_OFF: assert property ( // [RULE_13]
    (st_ff == ST_WCHK || ld_st) |-> !flow_ctl_en_out)
    else $error("flow control still active after line end");
  AST_NO_ECHO: assert property ( // [RULE_12]
    (st_ff == ST_WCHK || ld_st) && !tx_valid_out |=> !tx_valid_out)
    else $error("character echoed during checksum or data");
  AST_TMO_ABORT: assert property ( // [RULE_18]
    tmo_exp && (st_ff == ST_WCHK || st_ff == ST_LD_RX) |=> s_err_msg)
    else $error("missed deadline did not abort with error");
  AST_BAD_CHK: assert property ( // [RULE_06]
    st_ff == ST_WCHK && !tmo_exp && pend_ff && sum_in != 8'h00
    |=> s_err_msg ##1 tx_valid_out)
    else $error("bad command checksum not reported");
  AST_GOOD_CHK: assert property ( // [RULE_05]
    st_ff == ST_WCHK && !tmo_exp && pend_ff && sum_in == 8'h00 &&
    !bad_ff |=> s_prompt)
    else $error("good command checksum not prompted");
  AST_ADDR_INC: assert property ( // [RULE_22]
    mem_req_out && mem_ack_in |=>
    mem_addr_out == 32'($past(mem_addr_out) + 32'h1))
    else $error("address did not step by one");
  AST_LD_WRITE: assert property ( // [RULE_07]
    st_ff == ST_LD_WR |-> mem_req_out && mem_we_out && !dir_ff)
    else $error("load byte not written to memory");
  AST_UL_READ: assert property ( // [RULE_01]
    st_ff == ST_UL_RD && mem_req_out |-> !mem_we_out && dir_ff)
    else $error("unload did not read memory");
  AST_UL_SUM: assert property ( // [RULE_09]
    st_ff == ST_UL_SUM && !pause_ff && !tx_valid_out |=>
    tx_valid_out && tx_data_out == 8'(8'h00 - $past(sum_ff)))
    else $error("unload checksum byte wrong");
  AST_CNT_END: assert property ( // [RULE_02]
    st_ff == ST_LD_RX && pend_ff && !tmo_exp && cnt_ff == 32'h0
    |=> st_ff == ST_MSG)
    else $error("load did not end after data checksum");
  AST_RX_KEEP: assert property ( // [RULE_19]
    rx_valid_in |=> pend_ff && hold_ff == $past(rx_data_in))
    else $error("received byte not held for the engine");
endmodule : xload_engine

/* File: verif/xload_host.sv */
// Far-side model: host receiver with random stalls and a byte memory
`timescale 1ns/1ps
module xload_host (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        tx_valid_in,
  input  wire logic [7:0]  tx_data_in,
  output logic             tx_ready_out,
  input  wire logic        mem_req_in,
  input  wire logic        mem_we_in,
  input  wire logic [31:0] mem_addr_in,
  input  wire logic [7:0]  mem_wdata_in,
  output logic             mem_ack_out,
  output logic [7:0]       mem_rdata_out,
  output logic             mem_err_out
);
  logic [7:0] got [$];
  logic [7:0] mem [logic [31:0]];
  // Address whose access answers with a memory error; none by default
  logic [31:0] bad_addr = 32'hFFFF_FFFF;

  // Collect sent bytes; ready stalls at random
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_ready_out <= 1'b0;
    end else begin
      if (tx_valid_in && tx_ready_out) got.push_back(tx_data_in);
      tx_ready_out <= 1'($urandom % 2);
    end
  end

  // Answer accesses late at random; idle read data toggles
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_ack_out   <= 1'b0;
      mem_rdata_out <= 8'hA5;
      mem_err_out   <= 1'b0;
    end else if (mem_req_in && !mem_ack_out && ($urandom % 3 == 0)) begin
      mem_ack_out <= 1'b1;
      mem_err_out <= (mem_addr_in == bad_addr);
      if (mem_we_in) mem[mem_addr_in] = mem_wdata_in;
      else mem_rdata_out <= mem[mem_addr_in];
    end else begin
      mem_ack_out   <= 1'b0;
      mem_err_out   <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
    end
  end
endmodule : xload_host

/* File: verif/xload_engine_tb.sv */
// Self-checking bench for the binary load and unload engine
`timescale 1ns/1ps
module xload_engine_tb;
  import xload_pkg::*;
  localparam int unsigned TICKS = 4;
  localparam int unsigned TMO   = 50;
  logic        mclk_in = 1'b0;
  logic        rst_in  = 1'b1;
  logic        rx_valid, rx_err, tx_valid, tx_ready;
  logic        mem_req, mem_we, mem_ack, mem_err, flow_en;
  logic [7:0]  rx_data, tx_data, mem_wdata, mem_rdata, sum;
  logic [31:0] mem_addr;
  logic [7:0]  exp_q [$];
  logic [7:0]  dat [2];
  int          fail_count = 0;
  int          n_checks   = 0;

  always #5 mclk_in = ~mclk_in;

  xload_engine #(.TICK_CYCLES(TICKS), .TMO_TICKS(TMO)) i_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .rx_valid_in(rx_valid),
    .rx_data_in(rx_data), .rx_err_in(rx_err), .tx_ready_in(tx_ready),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data),
    .mem_req_out(mem_req), .mem_we_out(mem_we), .mem_addr_out(mem_addr),
    .mem_wdata_out(mem_wdata), .mem_ack_in(mem_ack),
    .mem_rdata_in(mem_rdata), .mem_err_in(mem_err),
    .flow_ctl_en_out(flow_en));

  xload_host i_host (
    .mclk_in(mclk_in), .rst_in(rst_in), .tx_valid_in(tx_valid),
    .tx_data_in(tx_data), .tx_ready_out(tx_ready), .mem_req_in(mem_req),
    .mem_we_in(mem_we), .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata),
    .mem_ack_out(mem_ack), .mem_rdata_out(mem_rdata),
    .mem_err_out(mem_err));

  task automatic end_of_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check8

  // One received byte, then a gap well inside the deadline
  task automatic send(input logic [7:0] b, input logic e);
    @(negedge mclk_in);
    rx_valid = 1'b1;
    rx_data  = b;
    rx_err   = e;
    @(negedge mclk_in);
    rx_valid = 1'b0;
    rx_err   = 1'b0;
    repeat (48) @(negedge mclk_in);
  endtask : send

  task automatic push_s(input string s);
    foreach (s[i]) exp_q.push_back(s[i]);
  endtask : push_s

  // Two's complement of an 8-bit running sum
  function automatic logic [7:0] neg8(input logic [7:0] s);
    return 8'(8'h00 - s);
  endfunction : neg8

  // Command line with echo expected up to any comment character
  task automatic cmd(input string s, input int cs);
    logic [7:0] lsum;
    bit         cmt;
    lsum = 8'h00;
    cmt  = 1'b0;
    foreach (s[i]) begin
      send(s[i], 1'b0);
      lsum += s[i];
      if (s[i] == "!") cmt = 1'b1;
      if (!cmt) exp_q.push_back(s[i]);
    end
    send(CH_CR, 1'b0);
    if (!cmt) check8({7'h00, flow_en}, 8'h00, "flow ctl");
    if (cs >= 0) send(8'(cs - int'(lsum)), 1'b0);
  endtask : cmd

  // Compare every sent byte against the expected stream
  task automatic check_tx();
    int k;
    k = 0;
    while (i_host.got.size() < exp_q.size() && k < 3000) begin
      @(negedge mclk_in);
      k++;
    end
    if (k == 3000) begin
      fail_count++;
      $display("[FAIL] %0t no reply", $time);
      end_of_test();
    end
    repeat (100) @(negedge mclk_in);
    check8(8'(i_host.got.size()), 8'(exp_q.size()), "tx count");
    foreach (exp_q[i]) begin
      if (i < i_host.got.size()) begin
        check8(i_host.got[i], exp_q[i], "tx");
      end
    end
    i_host.got.delete();
    exp_q.delete();
  endtask : check_tx

  initial begin
    int s;
    rx_valid = 1'b0;
    rx_err   = 1'b0;
    rx_data  = 8'h00;
    s = $urandom(91);
    repeat (3) @(negedge mclk_in);
    rst_in = 1'b0;
    check8({7'h00, tx_valid}, 8'h00, "reset tx");
    check8({7'h00, flow_en}, 8'h01, "reset flow");
    // Comment line is dropped without echo
    cmd("!X 1 1", -1);
    // Loads: line error, bad data sum, memory error, then a good one
    for (int k = 0; k < 4; k++) begin
      sum = 8'h00;
      i_host.bad_addr = (k == 2) ? 32'h121 : 32'hFFFF_FFFF;
      cmd($sformatf("X %0h 2", 32'h100 + 32'(k) * 32'h10), 0);
      push_s(">>>");
      for (int i = 0; i < 2; i++) begin
        dat[i] = 8'($urandom);
        send(dat[i], k == 0 && i == 1);
        sum += dat[i];
      end
      send(8'(int'(k == 1) - int'(sum)), 1'b0);
      if (k == 3) push_s(">>>");
      else push_s("?ERR\015\n>>>");
      check_tx();
    end
    for (int i = 0; i < 2; i++) begin
      check8(i_host.mem[32'h130 + i], dat[i], "mem");
    end
    // Bad command checksum: error, nothing stored
    cmd("X 140 1", 1);
    push_s("?ERR\015\n>>>");
    check_tx();
    check8(8'(i_host.mem.exists(32'h140)), 8'h00, "no load");
    // Missing command checksum runs out the deadline
    cmd("X 150 1", -1);
    push_s("?ERR\015\n>>>");
    check_tx();
    // Unload of the good load, then its negated sum
    cmd("X 130 80000002", 0);
    push_s(">>>");
    sum = 8'h00;
    foreach (dat[i]) begin
      exp_q.push_back(dat[i]);
      sum += dat[i];
    end
    exp_q.push_back(neg8(sum));
    push_s(">>>");
    check_tx();
    end_of_test();
  end
endmodule : xload_engine_tb
